// ==== design/mlw_pkg.sv ====
package mlw_pkg;

    // Motion modes
    typedef enum logic [2:0] {
        mode_idle,
        mode_torque,
        mode_vel_pid,
        mode_vel_profile,
        mode_impedance,
        mode_pos_pid,
        mode_pos_profile
    } motion_mode_t;

    // Clock and timing
    localparam int CLK_HZ = 200_000_000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_NS = 1_000_000;
    localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int SAMPLE_HZ = 40_000;
    localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;

    // Watchdog limits, milliseconds
    localparam logic [11:0] WDOG_RESET_MS = 12'd250;
    localparam logic [11:0] WDOG_MAX_MS = 12'd2000;

    // Encoder: 14 bit, 16384 counts per turn
    localparam int ENC_BITS = 14;
    localparam int POS_BITS = 32;
    localparam int VEL_BITS = 24;
    localparam int TRQ_BITS = 16;
    localparam int CUR_BITS = 16;

    // Low pass: 5 kHz at 40 kHz sampling; alpha 0.5, shift form
    localparam int LPF_CUTOFF_HZ = 5_000;
    localparam int LPF_SHIFT = 1;

    // Phase current limit after reset, in 10 mA units (10 A)
    localparam logic [15:0] CUR_LIMIT_RESET = 16'd1000;

    // Gear ratio as Q8.8 fixed point, 1.0 after reset
    localparam logic [15:0] GEAR_RESET = 16'h0100;
    localparam int GEAR_FRAC = 8;

    // Limit set grouped for the clamp stage
    typedef struct packed {
        logic signed [TRQ_BITS-1:0] max_torque;
        logic [VEL_BITS-1:0] max_vel;
        logic signed [POS_BITS-1:0] pos_min;
        logic signed [POS_BITS-1:0] pos_max;
    } limits_t;

    // Targets from host or loops
    typedef struct packed {
        logic signed [TRQ_BITS-1:0] torque;
        logic signed [VEL_BITS-1:0] vel;
        logic signed [POS_BITS-1:0] pos;
    } targets_t;

endpackage

// ==== design/wdog_timer.sv ====
`timescale 1ns/100ps
// Communication watchdog: counts ms ticks since the last frame
module wdog_timer (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic [11:0] i_timeout_ms,
    input wire logic i_frame,
    // Status
    output logic o_expired
);
    logic [17:0] tick_cnt;
    logic [11:0] ms_cnt;
    wire tick = (tick_cnt == 18'(mlw_pkg::CYCLES_PER_MS - 1));
    wire disabled = (i_timeout_ms == 12'h000);
    wire [11:0] limit = (i_timeout_ms > mlw_pkg::WDOG_MAX_MS) ?
        mlw_pkg::WDOG_MAX_MS : i_timeout_ms;

    // A frame restarts the full timeout
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tick_cnt <= 18'h00000;
            ms_cnt <= 12'h000;
        end
        else if (i_frame || disabled)
        begin
            tick_cnt <= 18'h00000;
            ms_cnt <= 12'h000;
        end
        else
        begin
            tick_cnt <= tick ? 18'h00000 : tick_cnt + 18'h00001;
            if (tick && ms_cnt < limit)
                ms_cnt <= ms_cnt + 12'h001;
        end
    end

    // Zero setting never expires
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_expired <= 1'b0;
        else
            o_expired <= !disabled && !i_frame && (ms_cnt >= limit);
    end
endmodule

// ==== design/vel_estimator.sv ====
`timescale 1ns/100ps
// Differentiates position at 40 kHz, then first-order low pass
module vel_estimator (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Position
    input wire logic signed [31:0] i_pos,
    // Velocity, counts per sample
    output logic signed [23:0] o_vel
);
    logic [15:0] div;
    logic signed [31:0] last_pos;
    wire strobe = (div == 16'(mlw_pkg::SAMPLE_CYCLES - 1));
    wire signed [31:0] diff = i_pos - last_pos;
    wire signed [23:0] raw = diff[23:0];
    wire signed [23:0] step = (raw - o_vel) >>> mlw_pkg::LPF_SHIFT;

    // Sample clock divider and filter update
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            div <= 16'h0000;
            last_pos <= 32'h00000000;
            o_vel <= 24'h000000;
        end
        else
        begin
            div <= strobe ? 16'h0000 : div + 16'h0001;
            if (strobe)
            begin
                last_pos <= i_pos;
                o_vel <= o_vel + step;
            end
        end
    end
endmodule

// ==== design/motion_limit_watchdog.sv ====
`timescale 1ns/100ps
module motion_limit_watchdog (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Encoder, asynchronous to the clock
    input wire logic [13:0] i_enc_angle,
    // Frame receiver, same clock
    input wire logic i_frame_valid,
    input wire logic i_wdog_load,
    input wire logic [11:0] i_wdog_ms,
    // Configuration, same clock
    input wire mlw_pkg::motion_mode_t i_mode,
    input wire mlw_pkg::limits_t i_limits,
    input wire logic [15:0] i_gear,
    input wire logic i_gear_load,
    // Stored settings restored from non-volatile memory at power-up
    input wire logic i_nv_restore,
    input wire logic signed [31:0] i_nv_zero,
    input wire logic [15:0] i_nv_cur_limit,
    input wire logic i_cur_load,
    input wire logic [15:0] i_cur_limit,
    // Targets and start command
    input wire mlw_pkg::targets_t i_target,
    input wire logic i_pos_loop_vel,
    input wire logic signed [23:0] i_loop_vel,
    input wire logic i_start,
    input wire logic i_flag_clear,
    // Phase current measurement and torque constant (Q8.8)
    input wire logic signed [15:0] i_phase_cur,
    input wire logic [15:0] i_kt,
    // Outputs to the control chain
    output mlw_pkg::targets_t o_target,
    output logic [15:0] o_cur_limit,
    output logic o_drive_en,
    // Feedback; position and velocity in output shaft frame, torque on the motor side
    output logic signed [31:0] o_pos,
    output logic signed [23:0] o_vel,
    output logic signed [15:0] o_torque,
    // Status
    output logic o_warn,
    output logic o_err,
    output logic o_wdog_expired
);
    // Encoder synchroniser; a word is used only once two synced
    // samples agree, so a torn sample never slips a whole turn
    logic [13:0] enc_meta;
    logic [13:0] enc_sync;
    logic [13:0] enc_hold;
    logic [13:0] enc_last;
    logic signed [31:0] turns_pos;
    logic signed [31:0] zero;
    logic [11:0] wdog_ms;
    logic [15:0] gear;
    logic [15:0] cur_limit;
    logic wdog_exp;
    logic signed [23:0] vel_raw;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            enc_meta <= 14'h0000;
            enc_sync <= 14'h0000;
            enc_hold <= 14'h0000;
        end
        else
        begin
            enc_meta <= i_enc_angle;
            enc_sync <= enc_meta;
            enc_hold <= enc_sync;
        end
    end

    // Signed 14-bit step handles the wrap at 16383 to 0
    wire enc_stable = (enc_sync == enc_hold);
    wire signed [13:0] enc_step = enc_sync - enc_last;
    wire signed [31:0] pos_rel = turns_pos - zero;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            enc_last <= 14'h0000;
            turns_pos <= 32'h00000000;
        end
        else if (enc_stable)
        begin
            enc_last <= enc_sync;
            turns_pos <= turns_pos + 32'(enc_step);
        end
    end

    // Settings: reset values, then stored or host values
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            zero <= 32'h00000000;
            wdog_ms <= mlw_pkg::WDOG_RESET_MS;
            gear <= mlw_pkg::GEAR_RESET;
            cur_limit <= mlw_pkg::CUR_LIMIT_RESET;
        end
        else
        begin
            if (i_nv_restore)
            begin
                zero <= i_nv_zero;
                cur_limit <= i_nv_cur_limit;
            end
            else if (i_cur_load)
                cur_limit <= i_cur_limit;
            if (i_wdog_load)
                wdog_ms <= i_wdog_ms;
            if (i_gear_load)
                gear <= i_gear;
        end
    end

    wdog_timer u_wdog (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_timeout_ms(wdog_ms),
        .i_frame(i_frame_valid),
        .o_expired(wdog_exp)
    );

    vel_estimator u_vel (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_pos(pos_rel),
        .o_vel(vel_raw)
    );

    // Mode gating of the limits
    wire pos_mode = (i_mode == mlw_pkg::mode_impedance) ||
        (i_mode == mlw_pkg::mode_pos_pid) ||
        (i_mode == mlw_pkg::mode_pos_profile);
    wire vel_mode = (i_mode == mlw_pkg::mode_vel_pid) ||
        (i_mode == mlw_pkg::mode_vel_profile) || pos_mode;

    // Torque clamp, symmetric about zero
    wire signed [15:0] t_max = i_limits.max_torque;
    wire signed [15:0] t_in = i_target.torque;
    wire t_hi = t_in > t_max;
    wire t_lo = t_in < -t_max;
    wire signed [15:0] t_out = t_hi ? t_max : (t_lo ? -t_max : t_in);

    // Velocity clamp on host or position-loop target
    wire signed [23:0] v_in = i_pos_loop_vel ? i_loop_vel : i_target.vel;
    wire signed [23:0] v_max = i_limits.max_vel;
    wire v_hi = vel_mode && (v_in > v_max);
    wire v_lo = vel_mode && (v_in < -v_max);
    wire signed [23:0] v_out = v_hi ? v_max : (v_lo ? -v_max : v_in);

    // Position clamp into the min..max range
    wire signed [31:0] p_in = i_target.pos;
    wire p_hi = pos_mode && (p_in > i_limits.pos_max);
    wire p_lo = pos_mode && (p_in < i_limits.pos_min);
    wire signed [31:0] p_out = p_hi ? i_limits.pos_max :
        (p_lo ? i_limits.pos_min : p_in);

    wire warn_evt = t_hi || t_lo || v_hi || v_lo || p_hi || p_lo;
    wire out_range = (pos_rel > i_limits.pos_max) ||
        (pos_rel < i_limits.pos_min);
    wire err_evt = i_start && pos_mode && out_range;

    // Gear scaling: Q8.8 ratio, output = motor / ratio is avoided by
    // storing the inverse ratio, so a multiply suffices
    function automatic logic signed [31:0] gear_scale(
        input logic signed [31:0] v,
        input logic [15:0] g
    );
        logic signed [48:0] prod;
        prod = v * $signed({1'b0, g});
        return prod[39:8];
    endfunction

    // Torque from phase current times torque constant
    wire signed [31:0] trq_motor = gear_scale(32'(i_phase_cur), i_kt);
    wire signed [31:0] vel_shaft = gear_scale(32'(vel_raw), gear);

    // Every output is registered so the top drives straight from flops

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_target <= '0;
            o_cur_limit <= mlw_pkg::CUR_LIMIT_RESET;
            o_pos <= 32'h00000000;
            o_vel <= 24'h000000;
            o_torque <= 16'h0000;
        end
        else
        begin
            o_target.torque <= t_out;
            o_target.vel <= v_out;
            o_target.pos <= p_out;
            o_cur_limit <= cur_limit;
            o_pos <= gear_scale(pos_rel, gear);
            o_vel <= vel_shaft[23:0];
            o_torque <= trq_motor[15:0];
        end
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_warn <= 1'b0;
            o_err <= 1'b0;
        end
        else
        begin
            o_warn <= warn_evt || (o_warn && !i_flag_clear);
            o_err <= err_evt || (o_err && !i_flag_clear);
        end
    end

    // Power stage held off while the link is silent
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_drive_en <= 1'b0;
            o_wdog_expired <= 1'b0;
        end
        else
        begin
            o_drive_en <= !wdog_exp;
            o_wdog_expired <= wdog_exp;
        end
    end

    // Drive stage must be off once the watchdog has expired
    chk_wdog_kills_drive: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        wdog_exp |=> !o_drive_en)
        else $error("drive enabled after watchdog expiry");

    chk_zero_never_expires: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (wdog_ms == 12'h000) |=> !wdog_exp)
        else $error("watchdog expired while disabled");

    chk_frame_restarts: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_frame_valid |=> !wdog_exp)
        else $error("watchdog expired right after a frame");

    chk_torque_clamp: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        t_hi |=> (o_target.torque == $past(t_max)) && o_warn)
        else $error("torque not clamped with warning");

    chk_vel_mode_gate: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !vel_mode |=> (o_target.vel == $past(v_in)))
        else $error("velocity limited outside its modes");

    chk_vel_clamp: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        v_hi |=> (o_target.vel == $past(v_max)) && o_warn)
        else $error("velocity not clamped with warning");

    chk_pos_clamp: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        p_lo |=> (o_target.pos == $past(i_limits.pos_min)) && o_warn)
        else $error("position not clamped with warning");

    chk_start_error: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        err_evt |=> o_err ##1 (o_err || $past(i_flag_clear)))
        else $error("start outside range gave no error");

    sequence warn_held_s;
        o_warn && !i_flag_clear && !warn_evt;
    endsequence

    chk_flag_sticky: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        warn_held_s |=> o_warn)
        else $error("warning dropped without clear");
endmodule

// ==== verif/host_frames.sv ====
`timescale 1ns/100ps
// Host behind the translator: a frame strobe every PERIOD cycles
module host_frames #(parameter int PERIOD = 1000) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Frames flow only while running
    input wire logic i_run,
    // Frame strobe toward the drive
    output logic o_frame
);
    int cnt;

    // Acts like a flop, so the drive never races the strobe
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n || !i_run)
        begin
            cnt <= 0;
            o_frame <= 1'b0;
        end
        else
        begin
            o_frame <= (cnt == 0);
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        end
    end
endmodule

// ==== verif/motion_limit_watchdog_tb.sv ====
`timescale 1ns/100ps
module motion_limit_watchdog_tb;
    logic i_clk = 0;
    logic i_rst_n = 0;
    logic run = 0;
    logic frame, den, warn, err, wexp;
    logic wload = 0, gload = 0, nvr = 0, cload = 0, pl = 0, start = 0, fclr = 0;
    logic [13:0] enc = '0;
    logic [11:0] wms = '0;
    logic [15:0] gear = 16'h0100, cur = '0, nvcur = 16'h01f4, kt = 16'h0100;
    logic [15:0] ocur;
    logic signed [15:0] ph = 16'h0064;
    logic signed [15:0] otq;
    logic signed [31:0] zero = '0;
    logic signed [31:0] opos;
    logic signed [23:0] lv = '0;
    logic signed [23:0] ovel;
    logic [13:0] steps [5] =
        '{14'h1000, 14'h2000, 14'h3000, 14'h0000, 14'h1000};
    mlw_pkg::motion_mode_t mode = mlw_pkg::mode_idle;
    mlw_pkg::limits_t lim =
        '{16'h0064, 24'h0000c8, 32'hffffff9c, 32'h00000064};
    mlw_pkg::targets_t tgt = '0;
    mlw_pkg::targets_t otg;
    int err_count = 0;
    int tests_run = 0;
    int cnt;

    // 200 MHz
    always #2.5 i_clk = ~i_clk;

    host_frames host_frames_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_run(run), .o_frame(frame));

    motion_limit_watchdog motion_limit_watchdog_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_enc_angle(enc),
        .i_frame_valid(frame), .i_wdog_load(wload), .i_wdog_ms(wms),
        .i_mode(mode), .i_limits(lim), .i_gear(gear), .i_gear_load(gload),
        .i_nv_restore(nvr), .i_nv_zero(zero), .i_nv_cur_limit(nvcur),
        .i_cur_load(cload), .i_cur_limit(cur), .i_target(tgt),
        .i_pos_loop_vel(pl), .i_loop_vel(lv), .i_start(start),
        .i_flag_clear(fclr), .i_phase_cur(ph), .i_kt(kt),
        .o_target(otg), .o_cur_limit(ocur), .o_drive_en(den),
        .o_pos(opos), .o_vel(ovel), .o_torque(otq), .o_warn(warn),
        .o_err(err), .o_wdog_expired(wexp));

    task automatic check(input string nm, input logic signed [31:0] seen,
        input logic signed [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %0d seen %0d", nm, exp, seen);
        end
    endtask

    // Inputs set here only ever change at the falling edge; frame from host_frames changes at the rising edge
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic clear_flags;
        fclr = 1;
        cyc(1);
        fclr = 0;
        cyc(2);
    endtask

    task automatic tally_and_finish;
        $display("checks run %0d, errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        cyc(16);
        check("cur limit rst", ocur, 32'h000003e8);
        check("drive rst", den, 32'h0);
        i_rst_n = 1;
        run = 1;
        cyc(4);
        check("drive up", den, 32'h1);
        check("torque est", otq, 32'h00000064);
        // Every mode: torque always clamped, vel and pos only where due
        for (int m = 0; m < 7; m++)
        begin
            mode = mlw_pkg::motion_mode_t'(m);
            tgt = '{16'h01f4, 24'h0003e8, 32'h00002710};
            cyc(2);
            check("torque", otg.torque, 32'h00000064);
            check("vel", otg.vel, (m >= 2) ? 32'hc8 : 32'h3e8);
            check("pos", otg.pos, (m >= 4) ? 32'h64 : 32'h2710);
            check("warn", warn, 32'h1);
            tgt = '{16'hfe0c, 24'h000000, 32'hffffd8f0};
            cyc(2);
            check("torque neg", otg.torque, 32'hffffff9c);
            check("pos neg", otg.pos,
                (m >= 4) ? 32'hffffff9c : 32'hffffd8f0);
            tgt = '0;
            cyc(2);
            check("warn held", warn, 32'h1);
            clear_flags();
            check("warn clr", warn, 32'h0);
        end
        // Velocity coming from the position loop
        mode = mlw_pkg::mode_pos_pid;
        pl = 1;
        lv = 24'h001388;
        cyc(2);
        check("loop vel", otg.vel, 32'h000000c8);
        pl = 0;
        // Start outside the range: error only in position modes
        lim.pos_min = 32'h0000000a;
        lim.pos_max = 32'h00000014;
        mode = mlw_pkg::mode_torque;
        start = 1;
        cyc(1);
        start = 0;
        cyc(2);
        check("err torque", err, 32'h0);
        mode = mlw_pkg::mode_pos_pid;
        start = 1;
        cyc(1);
        start = 0;
        cyc(2);
        check("err start", err, 32'h1);
        lim.pos_min = 32'hffffff9c;
        lim.pos_max = 32'h00000064;
        clear_flags();
        check("err clr", err, 32'h0);
        // One and a quarter turns in quarter steps
        foreach (steps[i])
        begin
            enc = steps[i];
            cyc(6);
        end
        check("pos turns", opos, 32'h00005000);
        zero = 32'h000003e8;
        nvr = 1;
        cyc(1);
        nvr = 0;
        cyc(6);
        check("pos zero", opos, 32'h00004c18);
        check("cur nv", ocur, 32'h000001f4);
        cur = 16'h02bc;
        cload = 1;
        cyc(1);
        cload = 0;
        cyc(2);
        check("cur load", ocur, 32'h000002bc);
        gear = 16'h0080;
        gload = 1;
        cyc(1);
        gload = 0;
        cyc(6);
        check("pos gear", opos, 32'h0000260c);
        // Slow steady motion, one step per sample period
        repeat (4)
        begin
            enc = enc + 14'h0040;
            cyc(mlw_pkg::SAMPLE_CYCLES);
        end
        check("vel sign", ovel > 24'sh0, 32'h1);
        // Shortest timeout: alive with frames, trips once they stop
        wms = 12'h001;
        wload = 1;
        cyc(1);
        wload = 0;
        cyc(3000);
        check("alive", den, 32'h1);
        run = 0;
        cnt = 0;
        while (den === 1'b1 && cnt < 32'h320c8)
        begin
            cyc(1);
            cnt++;
        end
        check("trip", cnt >= 32'h30958 && cnt <= 32'h31128, 32'h1);
        // A hung trip skips the rest; the failed trip check counts it
        if (cnt < 32'h320c8)
        begin
            check("expired", wexp, 32'h1);
            run = 1;
            cyc(4);
            check("revive", den, 32'h1);
            // Zero timeout: silence must never cut the drive
            wms = 12'h000;
            wload = 1;
            cyc(1);
            wload = 0;
            run = 0;
            cyc(32'h33450);
            check("wdog off", den, 32'h1);
        end
        tally_and_finish();
    end
endmodule
